// File: src/synth_serial_pkg.sv
// Constants shared by the serial load and pin control logic
package synth_serial_pkg;
  // ==========================================================
  // Serial word
  localparam int WORD_BITS = 24;
  localparam int CTL_LSB = 0;
  localparam int CTL_MSB = 1;
  localparam int EXT_LSB = 2;
  localparam int EXT_MSB = 3;
  localparam int NUM_CTL_REGS = 6;
  localparam logic [1:0] CTL_EXTENDED = 2'h3;
  localparam logic [2:0] EXT_BASE = 3'h3;
  localparam logic [2:0] FUNC_IDX = 3'h5;
  localparam logic [WORD_BITS-1:0] CTL_RESET = 24'h000000;
  // ==========================================================
  // Fields of the function register
  localparam int RF_PD_BIT = 4;
  localparam int IF_PD_BIT = 5;
  localparam int RF_SPD_LSB = 6;
  localparam int IF_SPD_LSB = 8;
  localparam int MUX_LSB = 10;
  // ==========================================================
  // Speed-up pin modes
  localparam logic [1:0] SPD_FASTLOCK = 2'h0;
  localparam logic [1:0] SPD_GP_LOW = 2'h1;
  localparam logic [1:0] SPD_GP_HIGH = 2'h2;
  localparam logic [1:0] SPD_HIZ = 2'h3;
  // ==========================================================
  // Test/lock multiplexer sources
  localparam logic [3:0] MUX_GP_LOW = 4'h0;
  localparam logic [3:0] MUX_GP_HIGH = 4'h1;
  localparam logic [3:0] MUX_HIZ = 4'h2;
  localparam logic [3:0] MUX_RF_N = 4'h3;
  localparam logic [3:0] MUX_RF_R = 4'h4;
  localparam logic [3:0] MUX_IF_N = 4'h5;
  localparam logic [3:0] MUX_IF_R = 4'h6;
  localparam logic [3:0] MUX_PP_RF = 4'h7;
  localparam logic [3:0] MUX_PP_IF = 4'h8;
  localparam logic [3:0] MUX_OD_RF = 4'h9;
  localparam logic [3:0] MUX_OD_IF = 4'ha;
  localparam logic [3:0] MUX_DLD_RF = 4'hb;
  localparam logic [3:0] MUX_DLD_IF = 4'hc;
endpackage : synth_serial_pkg

// File: src/pin_sync.sv
// Two-stage synchroniser with rising-edge detect for serial port pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule : pin_sync
`default_nettype wire

// File: src/synth_serial_load_and_pin_control.sv
// Serial programming port, control registers and output pin control
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Data is sampled into a 24-bit shift register on each serial clock rise.
// - Last two bits shifted in choose the destination control register; when both are set, the two bits before them choose it.
// - Strobe rising edge copies the shift register into one of six registers.
// - Chip enable high powers both loops; register bits then gate power-down.
// - Chip enable low powers down at once and floats both pump outputs.
// - Oscillator force-on keeps the reference buffer powered whatever chip enable is.
// - Force-on low: shared pin is IF speed-up switch or general-purpose tri-state.
// - Force-on high: shared pin carries the oscillator output.
// - RF speed-up pin switches resistor in fast acquisition, or general-purpose tri-state.
// - Test/lock pin selects GP, divider, analog or filtered lock source per loop.
module synth_serial_load_and_pin_control
  import synth_serial_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic chip_en,
  input wire logic osc_buffer_force_on,
  input wire logic ref_osc_in,
  input wire logic rf_fastlock_active,
  input wire logic if_fastlock_active,
  input wire logic rf_n_div,
  input wire logic rf_r_div,
  input wire logic if_n_div,
  input wire logic if_r_div,
  input wire logic rf_lock_analog,
  input wire logic if_lock_analog,
  input wire logic rf_lock_digital,
  input wire logic if_lock_digital,
  output logic rf_loop_powered,
  output logic if_loop_powered,
  output logic rf_pump_out_en,
  output logic if_pump_out_en,
  output logic osc_buffer_on,
  output logic ref_out_or_if_speedup_o,
  output logic ref_out_or_if_speedup_oe,
  output logic rf_speedup_out_o,
  output logic rf_speedup_out_oe,
  output logic test_lock_mux_out_o,
  output logic test_lock_mux_out_oe,
  output logic [NUM_CTL_REGS-1:0][WORD_BITS-1:0] ctl_regs
);
  // ==========================================================
  // Pin synchronisers
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  wire logic sdata_s = pin_level[1];
  wire logic sclk_rise = pin_rise[0];
  wire logic strobe_rise = pin_rise[2];

  // Data is synchronised with the same delay as the clock, so the edge sees the matching bit
  pin_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({load_strobe, serial_data, serial_clk}),
    .level(pin_level),
    .rise(pin_rise)
  );

  // ==========================================================
  // Shift register and latch
  function automatic logic [3:0] target_of(input logic [WORD_BITS-1:0] w);
    logic [1:0] ctl;
    logic [1:0] ext;
    ctl = w[CTL_MSB:CTL_LSB];
    ext = w[EXT_MSB:EXT_LSB];
    if (ctl != CTL_EXTENDED) begin
      target_of = {1'b1, 1'b0, ctl};
    end else begin
      target_of = {ext != 2'h3, EXT_BASE + {1'b0, ext}};
    end
  endfunction : target_of

  logic [WORD_BITS-1:0] shift_q;
  logic [NUM_CTL_REGS-1:0][WORD_BITS-1:0] ctl_q;
  wire logic [3:0] target = target_of(shift_q);
  wire logic target_ok = target[3];
  wire logic [2:0] target_idx = target[2:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= CTL_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_BITS-2:0], sdata_s};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= '{default: CTL_RESET};
    end else if (strobe_rise && target_ok) begin
      ctl_q[target_idx] <= shift_q;
    end
  end

  assign ctl_regs = ctl_q;

  // ==========================================================
  // Power control
  wire logic [WORD_BITS-1:0] func_w = ctl_q[FUNC_IDX];
  wire logic rf_pd = func_w[RF_PD_BIT];
  wire logic if_pd = func_w[IF_PD_BIT];
  wire logic [1:0] rf_spd_mode = func_w[RF_SPD_LSB+1:RF_SPD_LSB];
  wire logic [1:0] if_spd_mode = func_w[IF_SPD_LSB+1:IF_SPD_LSB];
  wire logic [3:0] mux_sel = func_w[MUX_LSB+3:MUX_LSB];

  // The raw pin gates power so that power-down needs no clock edge
  assign rf_loop_powered = chip_en & ~rf_pd;
  assign if_loop_powered = chip_en & ~if_pd;
  assign rf_pump_out_en = rf_loop_powered;
  assign if_pump_out_en = if_loop_powered;
  assign osc_buffer_on = osc_buffer_force_on | chip_en;

  // ==========================================================
  // Speed-up pins
  function automatic logic [1:0] speedup_drive(input logic [1:0] mode, input logic active);
    unique case (mode)
      SPD_FASTLOCK: speedup_drive = {active, 1'b0};
      SPD_GP_LOW: speedup_drive = 2'h2;
      SPD_GP_HIGH: speedup_drive = 2'h3;
      SPD_HIZ: speedup_drive = 2'h0;
    endcase
  endfunction : speedup_drive

  wire logic [1:0] if_drive = speedup_drive(if_spd_mode, if_fastlock_active);
  wire logic [1:0] rf_drive = speedup_drive(rf_spd_mode, rf_fastlock_active);
  logic rf_spd_o_q;
  logic rf_spd_oe_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_spd_o_q <= 1'b0;
      rf_spd_oe_q <= 1'b0;
    end else begin
      rf_spd_o_q <= rf_drive[0];
      rf_spd_oe_q <= rf_drive[1];
    end
  end

  assign rf_speedup_out_o = rf_spd_o_q;
  assign rf_speedup_out_oe = rf_spd_oe_q;
  // Reference output is a clock, so it bypasses the flops
  assign ref_out_or_if_speedup_o = osc_buffer_force_on ? ref_osc_in : if_drive[0];
  assign ref_out_or_if_speedup_oe = osc_buffer_force_on | if_drive[1];

  // ==========================================================
  // Test/lock multiplexer: {oe, value}
  logic [1:0] mux_d;
  always_comb begin
    unique case (mux_sel)
      MUX_GP_LOW: mux_d = 2'h2;
      MUX_GP_HIGH: mux_d = 2'h3;
      MUX_RF_N: mux_d = {1'b1, rf_n_div};
      MUX_RF_R: mux_d = {1'b1, rf_r_div};
      MUX_IF_N: mux_d = {1'b1, if_n_div};
      MUX_IF_R: mux_d = {1'b1, if_r_div};
      MUX_PP_RF: mux_d = {1'b1, rf_lock_analog};
      MUX_PP_IF: mux_d = {1'b1, if_lock_analog};
      MUX_OD_RF: mux_d = {~rf_lock_analog, 1'b0};
      MUX_OD_IF: mux_d = {~if_lock_analog, 1'b0};
      MUX_DLD_RF: mux_d = {1'b1, rf_lock_digital};
      MUX_DLD_IF: mux_d = {1'b1, if_lock_digital};
      default: mux_d = 2'h0;
    endcase
  end

  logic mux_o_q;
  logic mux_oe_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_o_q <= 1'b0;
      mux_oe_q <= 1'b0;
    end else begin
      mux_o_q <= mux_d[0];
      mux_oe_q <= mux_d[1];
    end
  end

  assign test_lock_mux_out_o = mux_o_q;
  assign test_lock_mux_out_oe = mux_oe_q;

  // ==========================================================
  // Assertions
  a_shift_bit_in: assert property (@(posedge clk) disable iff (!rst_n)
    sclk_rise |=> shift_q[0] == $past(sdata_s)) else $error("shift did not take data bit");
  a_shift_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
    sclk_rise |=> shift_q[WORD_BITS-1:1] == $past(shift_q[WORD_BITS-2:0])) else $error("shift lost order");
  a_latch_target: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_rise && target_ok |=> ctl_q[$past(target_idx)] == $past(shift_q)) else $error("latch missed register");
  a_latch_only_edge: assert property (@(posedge clk) disable iff (!rst_n)
    !(strobe_rise && target_ok) |=> $stable(ctl_q)) else $error("register changed without strobe");
  a_pump_off: assert property (@(posedge clk) disable iff (!rst_n)
    !chip_en |-> !rf_pump_out_en && !if_pump_out_en) else $error("pump driven with chip disabled");
  a_loop_power: assert property (@(posedge clk) disable iff (!rst_n)
    chip_en && !func_w[RF_PD_BIT] |-> rf_loop_powered) else $error("rf loop not powered");
  a_osc_forced: assert property (@(posedge clk) disable iff (!rst_n)
    osc_buffer_force_on |-> osc_buffer_on) else $error("osc buffer off while forced");
  a_osc_pin_out: assert property (@(posedge clk) disable iff (!rst_n)
    osc_buffer_force_on |-> ref_out_or_if_speedup_oe && ref_out_or_if_speedup_o == ref_osc_in)
    else $error("shared pin not oscillator");
  a_if_speedup: assert property (@(posedge clk) disable iff (!rst_n)
    !osc_buffer_force_on && if_spd_mode == SPD_FASTLOCK |-> ref_out_or_if_speedup_oe == if_fastlock_active)
    else $error("if speed-up wrong");
  a_rf_speedup: assert property (@(posedge clk) disable iff (!rst_n)
    rf_spd_mode == SPD_FASTLOCK ##1 rf_spd_mode == SPD_FASTLOCK |-> rf_speedup_out_oe == $past(rf_fastlock_active))
    else $error("rf speed-up wrong");
  a_mux_divider: assert property (@(posedge clk) disable iff (!rst_n)
    mux_sel == MUX_RF_N ##1 mux_sel == MUX_RF_N |-> test_lock_mux_out_oe && test_lock_mux_out_o == $past(rf_n_div))
    else $error("mux not rf divider");
  c_latch: cover property (@(posedge clk) disable iff (!rst_n) strobe_rise && target_ok);
  c_fastlock: cover property (@(posedge clk) disable iff (!rst_n) rf_speedup_out_oe && !osc_buffer_force_on);
  c_dld: cover property (@(posedge clk) disable iff (!rst_n) mux_sel == MUX_DLD_RF && test_lock_mux_out_o);
endmodule : synth_serial_load_and_pin_control
`default_nettype wire

// File: dv/serial_host.sv
// Host-side model driving the three-wire programming port
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  input wire logic clk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  // ==========================================================
  // Idle: serial clock parked low between frames, strobe low
  initial begin
    serial_clk = 1'h0;
    serial_data = 1'h0;
    load_strobe = 1'h0;
  end
  // Half is the half period in fast clocks: 4 gives 200 ns, 3 gives 150 ns and is the fastest the bench uses
  // Data moves on the falling serial edge, so it has a full half period to settle before the rise
  task automatic send_bits(input logic [31:0] bits, input int n, input int half);
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= bits[i];
      repeat (half) @(posedge clk);
      serial_clk <= 1'h1;
      repeat (half) @(posedge clk);
      serial_clk <= 1'h0;
    end
    repeat (4) @(posedge clk);
    // Released data line flips so a stale bit never looks valid
    serial_data <= ~bits[0];
    load_strobe <= 1'h1;
    repeat (4) @(posedge clk);
    load_strobe <= 1'h0;
  endtask : send_bits
endmodule : serial_host
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the serial load and pin control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import synth_serial_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [12:0] side_in = 13'h0000;
  logic [31:0] lfsr_q = 32'h0f3c7a9a;
  logic [WORD_BITS-1:0] word;
  int errors = 0;
  int checks = 0;
  logic sclk, sdat, lstb, rf_pw, if_pw, rf_pe, if_pe, osc_on, sh_o, sh_oe, rs_o, rs_oe, tl_o, tl_oe;
  logic [NUM_CTL_REGS-1:0][WORD_BITS-1:0] regs, prev;
  logic [2:0] q_idx[$];
  logic [WORD_BITS-1:0] q_word[$];
  always #25 clk = ~clk;
  serial_host host (.clk(clk), .serial_clk(sclk), .serial_data(sdat), .load_strobe(lstb));
  synth_serial_load_and_pin_control dut (.clk(clk), .rst_n(rst_n), .serial_clk(sclk), .serial_data(sdat),
    .load_strobe(lstb), .chip_en(side_in[0]), .osc_buffer_force_on(side_in[1]), .ref_osc_in(side_in[2]),
    .rf_fastlock_active(side_in[3]), .if_fastlock_active(side_in[4]), .rf_n_div(side_in[5]),
    .rf_r_div(side_in[6]), .if_n_div(side_in[7]), .if_r_div(side_in[8]), .rf_lock_analog(side_in[9]),
    .if_lock_analog(side_in[10]), .rf_lock_digital(side_in[11]), .if_lock_digital(side_in[12]),
    .rf_loop_powered(rf_pw), .if_loop_powered(if_pw), .rf_pump_out_en(rf_pe), .if_pump_out_en(if_pe),
    .osc_buffer_on(osc_on), .ref_out_or_if_speedup_o(sh_o), .ref_out_or_if_speedup_oe(sh_oe),
    .rf_speedup_out_o(rs_o), .rf_speedup_out_oe(rs_oe), .test_lock_mux_out_o(tl_o),
    .test_lock_mux_out_oe(tl_oe), .ctl_regs(regs));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], 1'h0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : next_rand
  function automatic logic [1:0] spd_exp(input logic [1:0] m, input logic act);
    case (m)
      SPD_FASTLOCK: return {act, 1'h0};
      SPD_GP_LOW: return 2'h2;
      SPD_GP_HIGH: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction : spd_exp
  function automatic logic [1:0] mux_exp(input logic [3:0] m);
    case (m)
      MUX_GP_LOW: return 2'h2;
      MUX_GP_HIGH: return 2'h3;
      MUX_RF_N: return {1'h1, side_in[5]};
      MUX_RF_R: return {1'h1, side_in[6]};
      MUX_IF_N: return {1'h1, side_in[7]};
      MUX_IF_R: return {1'h1, side_in[8]};
      MUX_PP_RF: return {1'h1, side_in[9]};
      MUX_PP_IF: return {1'h1, side_in[10]};
      MUX_OD_RF: return {~side_in[9], 1'h0};
      MUX_OD_IF: return {~side_in[10], 1'h0};
      MUX_DLD_RF: return {1'h1, side_in[11]};
      MUX_DLD_IF: return {1'h1, side_in[12]};
      default: return 2'h0;
    endcase
  endfunction : mux_exp
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic fail(input string msg);
    errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail
  task automatic check_bit(input logic [1:0] got, input logic [1:0] exp, input string what);
    checks++;
    if (got !== exp) fail(what);
  endtask : check_bit
  task automatic check_regs(input logic [NUM_CTL_REGS-1:0][WORD_BITS-1:0] exp);
    checks++;
    if (regs !== exp) fail("control registers");
  endtask : check_regs
  // Index 6 maps to extension code 3, which the block must drop
  task automatic send(input logic [2:0] idx, input logic [WORD_BITS-1:0] body, input int half);
    logic [WORD_BITS-1:0] w;
    w = body;
    if (idx < 3'h3) w[CTL_MSB:CTL_LSB] = idx[1:0];
    else begin
      w[CTL_MSB:CTL_LSB] = CTL_EXTENDED;
      w[EXT_MSB:EXT_LSB] = 2'(idx - 3'h3);
    end
    if (idx < 3'h6) begin
      q_idx.push_back(idx);
      q_word.push_back(w);
    end
    lfsr_q = next_rand(lfsr_q);
    host.send_bits({lfsr_q[7:0], w}, 32, half);
  endtask : send
  task automatic check_pins(input logic [WORD_BITS-1:0] f);
    logic [1:0] e;
    check_bit({rf_pw, if_pw}, {2{side_in[0]}} & ~{f[RF_PD_BIT], f[IF_PD_BIT]}, "loop power");
    check_bit({rf_pe, if_pe}, {2{side_in[0]}} & ~{f[RF_PD_BIT], f[IF_PD_BIT]}, "pump enable");
    check_bit({1'h0, osc_on}, {1'h0, side_in[1] | side_in[0]}, "osc buffer");
    e = side_in[1] ? {1'h1, side_in[2]} : spd_exp(f[IF_SPD_LSB+:2], side_in[4]);
    check_bit({sh_oe, sh_o}, e, "shared pin");
    check_bit({rs_oe, rs_o}, spd_exp(f[RF_SPD_LSB+:2], side_in[3]), "rf speed-up");
    check_bit({tl_oe, tl_o}, mux_exp(f[MUX_LSB+:4]), "test lock mux");
  endtask : check_pins
  // ==========================================================
  // Monitor: every register change must match the oldest latch note
  initial begin
    prev = '0;
    forever begin
      @(posedge clk);
      #2;
      if (rst_n && regs !== prev) begin
        if (q_idx.size() == 0) fail("unexpected latch");
        else begin
          prev[q_idx.pop_front()] = q_word.pop_front();
          check_regs(prev);
        end
        prev = regs;
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail("timeout");
    give_verdict;
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    check_regs('0);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) send(3'(i), lfsr_q[23:0], (i % 2 == 1) ? 3 : 4);
    $display("test register latch done");
    for (int i = 0; i < 16; i++) begin
      lfsr_q = next_rand(lfsr_q);
      word = lfsr_q[23:0];
      word[MUX_LSB+:4] = 4'(i);
      // Every speed-up mode of both pins is visited, not left to chance
      word[RF_SPD_LSB+:2] = 2'(i);
      word[IF_SPD_LSB+:2] = 2'(i >> 2);
      send(3'h5, word, 4);
      for (int k = 0; k < 4; k++) begin
        lfsr_q = next_rand(lfsr_q);
        @(posedge clk) side_in <= lfsr_q[12:0];
        repeat (2) @(posedge clk);
        #1;
        check_pins(word);
      end
    end
    $display("test pin control done");
    for (int t = 0; t < 50 && q_idx.size() != 0; t++) @(posedge clk);
    if (q_idx.size() != 0) fail("latch missing");
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
